// [pus_defines.svh]
// Constants of the power-up reset sequencer: timing figures and derived counts.
// Assumes the sequencer clock is the oscillator clock at PUS_CLK_MHZ.
`ifndef PUS_DEFINES_SVH
`define PUS_DEFINES_SVH

// ----------------------------------------
// Clock
// ----------------------------------------
`define PUS_CLK_MHZ          200

// ----------------------------------------
// Reset input filter
// ----------------------------------------
`define PUS_FILT_MIN_NS      500
`define PUS_FILT_MAX_NS      2000
`define PUS_FILT_MIN_CYC     ((`PUS_FILT_MIN_NS * `PUS_CLK_MHZ + 999) / 1000)
`define PUS_FILT_MAX_CYC     ((`PUS_FILT_MAX_NS * `PUS_CLK_MHZ) / 1000)

// ----------------------------------------
// Power-up phase lengths, oscillator cycles
// ----------------------------------------
`define PUS_PH_OSC_CYC       1032
`define PUS_PH_FUSE_CYC      1180
`define PUS_PH_PUMP_CYC      688
`define PUS_PH_BANK_CYC      617

// ----------------------------------------
// Domains and boot
// ----------------------------------------
`define PUS_NUM_DOM          8
`define PUS_ALWAYS_ON_IDX    3'h0
`define PUS_BOOT_ADDR        32'h0000_0000
`define PUS_DOM_RST_ON       8'hff

`endif

// [pus_dom_ctl.sv]
// Core power domain switches with one-time change during initialisation.
// Assumes software gates module clocks before it requests a power-down.
`timescale 1ns/100ps
`include "pus_defines.svh"
module pus_dom_ctl
   import pus_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   pus_dom_if.dom    d
);
   logic [`PUS_NUM_DOM-1:0] used_r;
   logic [`PUS_NUM_DOM-1:0] on_r;
   logic [`PUS_NUM_DOM-1:0] rst_n_r;
   logic                    ok;
   logic                    ack_r;
   logic                    err_r;

   // ----------------------------------------
   // Command check
   // ----------------------------------------
   assign ok = d.cmd_idx != `PUS_ALWAYS_ON_IDX && !used_r[d.cmd_idx] && !d.init_lock
               && (d.cmd_on || d.clk_gated[d.cmd_idx]);

   genvar i;
   generate
      for (i = 0; i < `PUS_NUM_DOM; i = i + 1) begin : g_dom
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               used_r[i]  <= 1'b0;
               on_r[i]    <= 1'b1;
               rst_n_r[i] <= 1'b0;
            end else if (d.por) begin
               used_r[i]  <= 1'b0;
               on_r[i]    <= 1'b1;
               rst_n_r[i] <= 1'b0;
            end else begin
               if (d.cmd_valid && ok && d.cmd_idx == 3'(i)) begin
                  used_r[i] <= 1'b1;
                  on_r[i]   <= d.cmd_on;
               end
               // Reset follows power one cycle late: asserted one cycle after power-off, held one cycle past repower
               rst_n_r[i] <= on_r[i];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         ack_r <= d.cmd_valid && ok;
         err_r <= d.cmd_valid && !ok;
      end
   end

   assign d.power_on  = on_r;
   assign d.dom_rst_n = rst_n_r;
   assign d.cmd_ack   = ack_r;
   assign d.cmd_err   = err_r;
endmodule

// [pus_dom_if.sv]
// Carrier between the sequencer top and its domain switch controller.
// Assumes both ends share one clock.
`timescale 1ns/100ps
`include "pus_defines.svh"
interface pus_dom_if;
   import pus_pkg::*;
   logic                     cmd_valid;
   pus_dom_idx_t             cmd_idx;
   logic                     cmd_on;
   logic [`PUS_NUM_DOM-1:0]  clk_gated;
   logic                     init_lock;
   logic                     por;
   logic [`PUS_NUM_DOM-1:0]  power_on;
   logic [`PUS_NUM_DOM-1:0]  dom_rst_n;
   logic                     cmd_ack;
   logic                     cmd_err;

   modport ctl (output cmd_valid, cmd_idx, cmd_on, clk_gated, init_lock, por,
                input  power_on, dom_rst_n, cmd_ack, cmd_err);
   modport dom (input  cmd_valid, cmd_idx, cmd_on, clk_gated, init_lock, por,
                output power_on, dom_rst_n, cmd_ack, cmd_err);
endinterface

// [pus_pkg.sv]
// Types shared by the power-up reset sequencer modules.
// Assumes pus_defines.svh for the numeric constants.
package pus_pkg;

   // ----------------------------------------
   // Sequencer phases, Gray along the path
   // ----------------------------------------
   typedef enum logic [2:0] {
      PUS_PH_OSC  = 3'h0,
      PUS_PH_FUSE = 3'h1,
      PUS_PH_PUMP = 3'h3,
      PUS_PH_BANK = 3'h2,
      PUS_PH_DONE = 3'h6
   } pus_phase_t;

   typedef logic [2:0] pus_dom_idx_t;

endpackage

// [pus_por_filter.sv]
// Glitch filter for the active-low power-on reset input.
// Assumes the input is already synchronous to clk.
`timescale 1ns/100ps
`include "pus_defines.svh"
module pus_por_filter
   import pus_pkg::*;
#(
   parameter int MIN_CYC = `PUS_FILT_MIN_CYC
)(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic por_n_in,
   output logic      por_valid
);
   // ----------------------------------------
   // Low-time counter
   // ----------------------------------------
   // Threshold at the short limit: anything between the limits may go either
   // way, so the earliest safe point is used to cut reset latency.
   logic [9:0] low_cnt_r;
   logic [9:0] low_cnt_nxt;
   logic       hit;

   assign hit         = (low_cnt_r >= 10'(MIN_CYC - 1));
   assign low_cnt_nxt = por_n_in ? 10'h000 : (hit ? low_cnt_r : low_cnt_r + 10'h001);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Start saturated so a line held low from reset keeps reset asserted
         low_cnt_r <= 10'(MIN_CYC - 1);
         por_valid <= 1'b1;
      end else begin
         low_cnt_r <= low_cnt_nxt;
         por_valid <= !por_n_in && hit;
      end
   end
endmodule

// [pus_supv_model.sv]
// Model of the external supply supervisor that drives the power-on reset line.
// Assumes the bench steers supply_ok and asks for timed low pulses.
`timescale 1ns/100ps
module pus_supv_model (
   input  wire logic       clk,
   input  wire logic       supply_ok,
   input  wire logic       pulse_go,
   input  wire logic [9:0] pulse_len,
   output logic            por_n
);
   // ----------------------------------------
   // Pulse timer
   // ----------------------------------------
   logic [9:0] cnt_r = 10'h000;
   always_ff @(posedge clk) begin
      if (pulse_go) begin
         cnt_r <= pulse_len;
      end else if (cnt_r != 10'h000) begin
         cnt_r <= cnt_r - 10'h001;
      end
   end
   // Line is always driven, so it never floats between pulses
   assign por_n = supply_ok & (cnt_r == 10'h000);
endmodule

// [pus_top.sv]
// Power-up reset sequencer: supply monitor response, reset filter, phases.
// Assumes all inputs synchronous to CLK, the oscillator clock.
`timescale 1ns/100ps
`include "pus_defines.svh"
module pus_top
   import pus_pkg::*;
#(
   parameter int PH_OSC_CYC  = `PUS_PH_OSC_CYC,
   parameter int PH_FUSE_CYC = `PUS_PH_FUSE_CYC,
   parameter int PH_PUMP_CYC = `PUS_PH_PUMP_CYC,
   parameter int PH_BANK_CYC = `PUS_PH_BANK_CYC
)(
   input  wire logic                    CLK,
   input  wire logic                    WARM_RESET_N,
   input  wire logic                    POWER_ON_RESET_N,
   input  wire logic                    CORE_LOW_DET,
   input  wire logic                    CORE_HIGH_DET,
   input  wire logic                    IO_LOW_DET,
   input  wire logic                    LOW_POWER_MODE,
   input  wire logic                    WARM_RESET_N_I,
   input  wire logic                    DOM_CMD_VALID,
   input  wire logic [2:0]              DOM_CMD_IDX,
   input  wire logic                    DOM_CMD_ON,
   input  wire logic [`PUS_NUM_DOM-1:0] DOM_CLK_GATED,
   input  wire logic                    INIT_DONE,
   input  wire logic                    BUS_REQ,
   input  wire logic [2:0]              BUS_DOM,
   output logic                         CORE_SUPPLY_GOOD,
   output logic                         IO_SUPPLY_GOOD,
   output logic                         PIN_HIZ,
   output logic                         WARM_RESET_N_O,
   output logic                         WARM_RESET_N_OE,
   output logic                         CPU_RESET_N,
   output logic [31:0]                  BOOT_ADDR,
   output logic [2:0]                   PHASE,
   output logic [`PUS_NUM_DOM-1:0]      DOM_POWER_ON,
   output logic [`PUS_NUM_DOM-1:0]      DOM_RESET_N,
   output logic                         DOM_CMD_ACK,
   output logic                         DOM_CMD_ERR,
   output logic                         BUS_DONE,
   output logic                         BUS_ABORT
);

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   pus_dom_if   dif ();
   pus_phase_t  phase_r;
   pus_phase_t  phase_nxt;
   logic [10:0] cnt_r;
   logic [10:0] cnt_nxt;
   logic [10:0] phase_len;
   logic        phase_last;
   logic        ext_por;
   logic        mon_en;
   logic        core_bad;
   logic        io_bad;
   logic        por_int;
   logic        seq_done;
   logic        init_lock_r;
   logic        bus_off;

   // ----------------------------------------
   // Reset input filter
   // ----------------------------------------
   pus_por_filter u_filt (
      .clk       (CLK),
      .rst_n     (WARM_RESET_N),
      .por_n_in  (POWER_ON_RESET_N),
      .por_valid (ext_por)
   );

   // ----------------------------------------
   // Supply monitor response
   // ----------------------------------------
   // In low power the comparators are not trusted, so their faults are dropped
   assign mon_en   = !LOW_POWER_MODE;
   assign core_bad = mon_en && (CORE_LOW_DET || CORE_HIGH_DET);
   assign io_bad   = mon_en && IO_LOW_DET;
   assign por_int  = ext_por || io_bad || core_bad;

   always_ff @(posedge CLK or negedge WARM_RESET_N) begin
      if (!WARM_RESET_N) begin
         CORE_SUPPLY_GOOD <= 1'b0;
         IO_SUPPLY_GOOD   <= 1'b0;
      end else begin
         CORE_SUPPLY_GOOD <= !core_bad;
         IO_SUPPLY_GOOD   <= !io_bad;
      end
   end

   // Set acts without the clock so pins float before the next edge
   always_ff @(posedge CLK or negedge WARM_RESET_N or posedge core_bad) begin
      if (!WARM_RESET_N) begin
         PIN_HIZ <= 1'b1;
      end else if (core_bad) begin
         PIN_HIZ <= 1'b1;
      end else begin
         PIN_HIZ <= 1'b0;
      end
   end

   // ----------------------------------------
   // Phase sequencer
   // ----------------------------------------
   assign phase_len = (phase_r == PUS_PH_OSC)  ? 11'(PH_OSC_CYC)  :
                      (phase_r == PUS_PH_FUSE) ? 11'(PH_FUSE_CYC) :
                      (phase_r == PUS_PH_PUMP) ? 11'(PH_PUMP_CYC) :
                                                 11'(PH_BANK_CYC);
   assign phase_last = (cnt_r == phase_len - 11'h001);
   assign seq_done   = (phase_r == PUS_PH_DONE);

   always_comb begin
      phase_nxt = phase_r;
      cnt_nxt   = cnt_r + 11'h001;
      case (phase_r)
         PUS_PH_OSC: begin
            if (phase_last) begin
               phase_nxt = PUS_PH_FUSE;
            end
         end
         PUS_PH_FUSE: begin
            if (phase_last) begin
               phase_nxt = PUS_PH_PUMP;
            end
         end
         PUS_PH_PUMP: begin
            if (phase_last) begin
               phase_nxt = PUS_PH_BANK;
            end
         end
         PUS_PH_BANK: begin
            if (phase_last) begin
               phase_nxt = PUS_PH_DONE;
            end
         end
         default: begin
            phase_nxt = PUS_PH_DONE;
            cnt_nxt   = 11'h000;
         end
      endcase
      if (phase_last) begin
         cnt_nxt = 11'h000;
      end
      if (por_int) begin
         phase_nxt = PUS_PH_OSC;
         cnt_nxt   = 11'h000;
      end
   end

   always_ff @(posedge CLK or negedge WARM_RESET_N) begin
      if (!WARM_RESET_N) begin
         phase_r <= PUS_PH_OSC;
         cnt_r   <= 11'h000;
      end else begin
         phase_r <= phase_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // ----------------------------------------
   // CPU reset and warm reset pin
   // ----------------------------------------
   // External warm reset only holds the CPU; it does not restart the phases
   always_ff @(posedge CLK or negedge WARM_RESET_N) begin
      if (!WARM_RESET_N) begin
         CPU_RESET_N     <= 1'b0;
         BOOT_ADDR       <= `PUS_BOOT_ADDR;
         PHASE           <= PUS_PH_OSC;
         WARM_RESET_N_O  <= 1'b0;
         WARM_RESET_N_OE <= 1'b1;
      end else begin
         CPU_RESET_N     <= seq_done && !por_int && WARM_RESET_N_I;
         BOOT_ADDR       <= `PUS_BOOT_ADDR;
         PHASE           <= phase_r;
         WARM_RESET_N_O  <= 1'b0;
         WARM_RESET_N_OE <= por_int || !seq_done;
      end
   end

   // ----------------------------------------
   // Domain switching
   // ----------------------------------------
   // Initialisation ends at the first INIT_DONE after CPU release; sticky to next reset
   always_ff @(posedge CLK or negedge WARM_RESET_N) begin
      if (!WARM_RESET_N) begin
         init_lock_r <= 1'b0;
      end else if (por_int) begin
         init_lock_r <= 1'b0;
      end else if (INIT_DONE && CPU_RESET_N) begin
         init_lock_r <= 1'b1;
      end
   end

   assign dif.cmd_valid = DOM_CMD_VALID && CPU_RESET_N;
   assign dif.cmd_idx   = DOM_CMD_IDX;
   assign dif.cmd_on    = DOM_CMD_ON;
   assign dif.clk_gated = DOM_CLK_GATED;
   assign dif.init_lock = init_lock_r;
   assign dif.por       = por_int;

   pus_dom_ctl u_dom (
      .clk   (CLK),
      .rst_n (WARM_RESET_N),
      .d     (dif.dom)
   );

   assign DOM_POWER_ON = dif.power_on;
   assign DOM_RESET_N  = dif.dom_rst_n;
   assign DOM_CMD_ACK  = dif.cmd_ack;
   assign DOM_CMD_ERR  = dif.cmd_err;

   // ----------------------------------------
   // Access check
   // ----------------------------------------
   assign bus_off = !dif.power_on[BUS_DOM];

   always_ff @(posedge CLK or negedge WARM_RESET_N) begin
      if (!WARM_RESET_N) begin
         BUS_DONE  <= 1'b0;
         BUS_ABORT <= 1'b0;
      end else begin
         BUS_DONE  <= BUS_REQ && !bus_off;
         BUS_ABORT <= BUS_REQ && bus_off;
      end
   end

endmodule

// [pus_top_props.sv]
// Concurrent checks on the ports of the power-up reset sequencer top.
// Assumes one clock domain and the async active-low reset WARM_RESET_N.
`timescale 1ns/100ps
module pus_top_props
   import pus_pkg::*;
(
   input wire logic        CLK,
   input wire logic        WARM_RESET_N,
   input wire logic        CORE_LOW_DET,
   input wire logic        CORE_HIGH_DET,
   input wire logic        IO_LOW_DET,
   input wire logic        LOW_POWER_MODE,
   input wire logic        DOM_CMD_VALID,
   input wire logic [2:0]  DOM_CMD_IDX,
   input wire logic        BUS_REQ,
   input wire logic [2:0]  BUS_DOM,
   input wire logic        CORE_SUPPLY_GOOD,
   input wire logic        IO_SUPPLY_GOOD,
   input wire logic        PIN_HIZ,
   input wire logic        WARM_RESET_N_O,
   input wire logic        WARM_RESET_N_OE,
   input wire logic        CPU_RESET_N,
   input wire logic [31:0] BOOT_ADDR,
   input wire logic [2:0]  PHASE,
   input wire logic [7:0]  DOM_POWER_ON,
   input wire logic        DOM_CMD_ACK,
   input wire logic        DOM_CMD_ERR,
   input wire logic        BUS_DONE,
   input wire logic        BUS_ABORT
);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!WARM_RESET_N);
   sequence s_io_fault;
      IO_LOW_DET && !LOW_POWER_MODE;
   endsequence
   sequence s_bank_end;
      PHASE == PUS_PH_BANK ##1 PHASE != PUS_PH_BANK;
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_io_good_low: assert property (s_io_fault |=> !IO_SUPPLY_GOOD)
      else $error("io supply good high during io fault");
   chk_core_good_low: assert property ((CORE_LOW_DET || CORE_HIGH_DET) && !LOW_POWER_MODE |=> !CORE_SUPPLY_GOOD)
      else $error("core supply good high during core fault");
   chk_io_fault_reset: assert property (s_io_fault |-> ##[1:2] !CPU_RESET_N)
      else $error("io fault did not reset the cpu");
   chk_pins_tristate: assert property (CORE_HIGH_DET && !LOW_POWER_MODE |-> PIN_HIZ)
      else $error("pins driven during core fault");
   chk_low_power_mask: assert property (LOW_POWER_MODE |=> CORE_SUPPLY_GOOD && IO_SUPPLY_GOOD)
      else $error("monitor active in low power mode");
   chk_pump_order: assert property ($changed(PHASE) && PHASE == PUS_PH_PUMP |-> $past(PHASE) == PUS_PH_FUSE)
      else $error("pump phase not entered from fuse phase");
   chk_bank_exit: assert property (s_bank_end |-> PHASE == PUS_PH_DONE || PHASE == PUS_PH_OSC)
      else $error("bank phase left to a wrong phase");
   chk_cpu_release: assert property ($rose(CPU_RESET_N) |-> PHASE == PUS_PH_DONE && BOOT_ADDR == 32'h0)
      else $error("cpu released before the last phase ended");
   chk_always_on: assert property (DOM_CMD_VALID && CPU_RESET_N && DOM_CMD_IDX == 3'h0 |=> DOM_CMD_ERR)
      else $error("always-on domain command not refused");
   chk_cmd_answer: assert property (DOM_CMD_VALID && CPU_RESET_N |=> DOM_CMD_ACK != DOM_CMD_ERR)
      else $error("domain command without single answer");
   chk_bus_abort: assert property (BUS_REQ && !DOM_POWER_ON[BUS_DOM] |=> BUS_ABORT && !BUS_DONE)
      else $error("access to off domain not aborted");
   chk_warm_low: assert property (PHASE != PUS_PH_DONE |-> WARM_RESET_N_OE && !WARM_RESET_N_O)
      else $error("warm reset pin not driven low");
endmodule

// [test_power_up_reset_sequencer.sv]
// Self-checking bench for the power-up reset sequencer top.
// Assumes pus_supv_model drives the power-on reset line.
`timescale 1ns/100ps
module test_power_up_reset_sequencer;
   import pus_pkg::*;
   // Short phases keep the run brief
   localparam int PH = 8;
   logic        clk, warm_reset_n, supply_ok, pulse_go, core_lo, core_hi, io_lo, lpm, warm_i, h, r;
   logic        cmd_v, cmd_on, init_done, bus_req, por_n, core_good, io_good, hiz;
   logic        warm_o, warm_oe, cpu_n, ack, err, done, abort;
   logic [9:0]  pulse_len;
   logic [7:0]  gated, pwr, drst;
   logic [2:0]  cmd_idx, bus_dom, phase;
   logic [31:0] boot;
   int          failures, check_count;

   pus_supv_model sup (.clk(clk), .supply_ok(supply_ok), .pulse_go(pulse_go), .pulse_len(pulse_len),
      .por_n(por_n));
   pus_top #(.PH_OSC_CYC(PH), .PH_FUSE_CYC(PH), .PH_PUMP_CYC(PH), .PH_BANK_CYC(PH)) dut (
      .CLK(clk), .WARM_RESET_N(warm_reset_n), .POWER_ON_RESET_N(por_n), .CORE_LOW_DET(core_lo), .CORE_HIGH_DET(core_hi),
      .IO_LOW_DET(io_lo), .LOW_POWER_MODE(lpm), .WARM_RESET_N_I(warm_i), .DOM_CMD_VALID(cmd_v),
      .DOM_CMD_IDX(cmd_idx), .DOM_CMD_ON(cmd_on), .DOM_CLK_GATED(gated), .INIT_DONE(init_done),
      .BUS_REQ(bus_req), .BUS_DOM(bus_dom), .CORE_SUPPLY_GOOD(core_good), .IO_SUPPLY_GOOD(io_good),
      .PIN_HIZ(hiz), .WARM_RESET_N_O(warm_o), .WARM_RESET_N_OE(warm_oe), .CPU_RESET_N(cpu_n),
      .BOOT_ADDR(boot), .PHASE(phase), .DOM_POWER_ON(pwr), .DOM_RESET_N(drst), .DOM_CMD_ACK(ack),
      .DOM_CMD_ERR(err), .BUS_DONE(done), .BUS_ABORT(abort));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic check(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         failures++;
         $display("mismatch %0t %s", $time, msg);
      end
   endtask

   task automatic test_done;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // One request of either kind; answer is read 1 ns after the edge that takes it
   task automatic op(input logic is_bus, input logic [2:0] idx, input logic on, output logic ok,
                     output logic bad);
      @(posedge clk);
      bus_req <= is_bus;
      cmd_v <= !is_bus;
      bus_dom <= idx;
      cmd_idx <= idx;
      cmd_on <= on;
      @(posedge clk);
      bus_req <= 1'b0;
      cmd_v <= 1'b0;
      #1;
      ok = is_bus ? done : ack;
      bad = is_bus ? abort : err;
   endtask

   task automatic pulse(input logic [9:0] n, output logic hit, output logic rep);
      int k;
      hit = 1'b0;
      rep = 1'b0;
      @(posedge clk);
      pulse_go <= 1'b1;
      pulse_len <= n;
      @(posedge clk);
      pulse_go <= 1'b0;
      for (k = 0; k < n + 4; k++) begin
         @(posedge clk);
         #1;
         if (cpu_n !== 1'b1) hit = 1'b1;
         if (pwr[2] === 1'b1 && drst[2] === 1'b0) rep = 1'b1;
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_sequence;
      logic [2:0] prev;
      int         len, k;
      logic [2:0] seen[$];
      int         lens[$];
      // Let the launching edge settle before the first look
      #1;
      prev = phase;
      len = 0;
      for (k = 0; k < 300 && cpu_n !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (phase !== prev) begin
            seen.push_back(prev);
            lens.push_back(len);
            prev = phase;
            len = 0;
         end
         len++;
         if (cpu_n !== 1'b1) check(warm_oe === 1'b1 && warm_o === 1'b0, "warm reset pin released");
      end
      if (cpu_n !== 1'b1) begin
         check(1'b0, "cpu reset never released");
         test_done();
      end else begin
         check(seen.size() == 4 && seen[1] === PUS_PH_FUSE && seen[3] === PUS_PH_BANK, "phase order");
         check(seen[0] === PUS_PH_OSC && seen[2] === PUS_PH_PUMP, "phase order");
         check(lens[1] == PH && lens[2] == PH && lens[3] == PH, "phase length");
         check(phase === PUS_PH_DONE && boot === 32'h0 && warm_oe === 1'b0, "release state");
      end
   endtask

   task automatic t_monitor;
      @(posedge clk) io_lo <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(io_good === 1'b0 && core_good === 1'b1 && cpu_n === 1'b0, "io fault");
      @(posedge clk) io_lo <= 1'b0;
      core_hi <= 1'b1;
      #1;
      check(hiz === 1'b1, "pins not tristated at once");
      repeat (2) @(posedge clk);
      #1;
      check(core_good === 1'b0 && io_good === 1'b1 && cpu_n === 1'b0, "core fault");
      @(posedge clk) core_hi <= 1'b0;
      lpm <= 1'b1;
      core_lo <= 1'b1;
      io_lo <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      check(core_good === 1'b1 && io_good === 1'b1 && hiz === 1'b0, "monitor active in low power");
      // Mask drops last so no fault shows for a moment
      @(posedge clk) core_lo <= 1'b0;
      io_lo <= 1'b0;
      lpm <= 1'b0;
      t_sequence();
   endtask

   task automatic t_domains;
      logic a, e, rep;
      op(1'b0, 3'h0, 1'b0, a, e);
      check(a === 1'b0 && e === 1'b1 && pwr[0] === 1'b1, "always-on domain switched");
      op(1'b0, 3'h2, 1'b0, a, e);
      check(e === 1'b1 && pwr[2] === 1'b1, "power-off with running clocks");
      @(posedge clk) gated <= 8'hff;
      op(1'b0, 3'h2, 1'b0, a, e);
      check(a === 1'b1 && pwr[2] === 1'b0, "power-off refused");
      @(posedge clk);
      #1;
      check(drst[2] === 1'b0, "off domain not held in reset");
      op(1'b1, 3'h2, 1'b0, a, e);
      check(a === 1'b0 && e === 1'b1, "off domain access not aborted");
      op(1'b1, 3'h1, 1'b0, a, e);
      check(a === 1'b1 && e === 1'b0, "live domain access aborted");
      op(1'b0, 3'h2, 1'b1, a, e);
      check(e === 1'b1 && pwr[2] === 1'b0, "second change taken");
      @(posedge clk) init_done <= 1'b1;
      @(posedge clk) init_done <= 1'b0;
      op(1'b0, 3'h3, 1'b0, a, e);
      check(e === 1'b1 && pwr[3] === 1'b1, "change after initialisation");
      pulse(10'h191, a, rep);
      check(rep === 1'b1, "domain repowered without reset");
      t_sequence();
      check(pwr === 8'hff && drst === 8'hff, "domains not at defaults");
      // External warm reset holds the CPU but leaves the phases alone
      @(posedge clk) warm_i <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(cpu_n === 1'b0 && phase === PUS_PH_DONE, "external warm reset ignored");
      @(posedge clk) warm_i <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      check(cpu_n === 1'b1, "cpu held after warm reset");
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      warm_reset_n = 1'b0;
      supply_ok = 1'b0;
      pulse_go = 1'b0;
      pulse_len = 10'h000;
      {core_lo, core_hi, io_lo, lpm, cmd_v, cmd_on, init_done, bus_req} = 8'h00;
      warm_i = 1'b1;
      gated = 8'h00;
      cmd_idx = 3'h0;
      bus_dom = 3'h0;
      failures = 0;
      check_count = 0;
      repeat (5) @(posedge clk);
      warm_reset_n <= 1'b1;
      @(posedge clk) supply_ok <= 1'b1;
      t_sequence();
      pulse(10'h063, h, r);
      check(h === 1'b0, "short reset pulse taken");
      pulse(10'h191, h, r);
      check(h === 1'b1, "long reset pulse ignored");
      t_sequence();
      t_monitor();
      t_domains();
      test_done();
   end
endmodule

bind pus_top pus_top_props u_props (.CLK(CLK), .WARM_RESET_N(WARM_RESET_N), .CORE_LOW_DET(CORE_LOW_DET),
   .CORE_HIGH_DET(CORE_HIGH_DET), .IO_LOW_DET(IO_LOW_DET), .LOW_POWER_MODE(LOW_POWER_MODE),
   .DOM_CMD_VALID(DOM_CMD_VALID), .DOM_CMD_IDX(DOM_CMD_IDX), .BUS_REQ(BUS_REQ), .BUS_DOM(BUS_DOM),
   .CORE_SUPPLY_GOOD(CORE_SUPPLY_GOOD), .IO_SUPPLY_GOOD(IO_SUPPLY_GOOD), .PIN_HIZ(PIN_HIZ),
   .WARM_RESET_N_O(WARM_RESET_N_O), .WARM_RESET_N_OE(WARM_RESET_N_OE), .CPU_RESET_N(CPU_RESET_N),
   .BOOT_ADDR(BOOT_ADDR), .PHASE(PHASE), .DOM_POWER_ON(DOM_POWER_ON), .DOM_CMD_ACK(DOM_CMD_ACK),
   .DOM_CMD_ERR(DOM_CMD_ERR), .BUS_DONE(BUS_DONE), .BUS_ABORT(BUS_ABORT));
